//--- hw/adcmc_top.v
// Converter mode control, sequencing and result readout
`timescale 1ns/1ns
`default_nettype none
`include "adcmc_defines.vh"

module adcmc_top
(
    // Clock and power-on reset
    input wire clk,
    input wire rst,
    // Standby entry, clears registers
    input wire standby,
    // Register access from the bus master
    input wire bus_req,
    input wire bus_we,
    input wire bus_word,
    input wire [7:0] bus_addr,
    input wire [15:0] bus_wdata,
    output reg [15:0] bus_rdata_q,
    output reg bus_ack_q,
    // Start triggers
    input wire multifunction_timer_trig,
    input wire external_trigger_pin_n,
    // Analog front end
    input wire [9:0] conversion_value_bits,
    output reg ana_sample_q,
    output reg ana_dual_q,
    output reg [2:0] ana_channel_q,
    output reg ana_fast_start_q,
    // Interrupt request
    output reg conversion_end_irq_q
);

    // ==========================================
    // State machine codes
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_CONV = 3'b010;
    localparam [2:0] ST_HOLD = 3'b100;

    // ==========================================
    // Control and status registers
    reg conversion_end_flag_q;
    reg end_interrupt_enable_q;
    reg conversion_run_bit_q;
    reg conv_clock_select_q;
    reg group_mode_select_q;
    reg [2:0] channel_code_q;
    reg start_mode_select_q;
    reg [1:0] trigger_source_q;
    reg scan_mode_q;
    reg dual_sample_enable_q;
    reg [1:0] buffer_chain_q;
    reg flag_seen_q;
    reg pin_prev_q;
    reg [2:0] state_q;
    reg [2:0] cur_ch_q;

    wire [7:0] conv_control_status;
    wire [7:0] conv_control;
    wire sel_csr;
    wire sel_ctrl;
    wire sel_res;
    wire wr_csr;
    wire wr_ctrl;
    wire [7:0] csr_wbyte;
    wire [7:0] ctrl_wbyte;
    wire hw_trigger;
    wire run_set;
    wire conv_done;
    wire last_ch;
    wire round_end;
    wire flag_clear;
    wire [2:0] first_ch;
    wire start_conv;
    wire [9:0] rd_value;
    wire timer_start;

    // ==========================================
    // Register images
    assign conv_control_status = {conversion_end_flag_q, end_interrupt_enable_q,
        conversion_run_bit_q, conv_clock_select_q, group_mode_select_q, channel_code_q};
    assign conv_control = {1'b0, start_mode_select_q, trigger_source_q,
        scan_mode_q, dual_sample_enable_q, buffer_chain_q};

    // ==========================================
    // Address decode, big-endian word at the status offset
    assign sel_csr = bus_addr == `ADCMC_OFS_CSR;
    assign sel_ctrl = bus_addr == `ADCMC_OFS_CTRL ||
        (bus_word && bus_addr == `ADCMC_OFS_CSR);
    assign sel_res = bus_addr >= `ADCMC_OFS_RES_BASE;
    assign wr_csr = bus_req && bus_we && sel_csr;
    assign wr_ctrl = bus_req && bus_we && sel_ctrl;
    assign csr_wbyte = bus_word ? bus_wdata[15:8] : bus_wdata[7:0];
    assign ctrl_wbyte = bus_wdata[7:0];

    // ==========================================
    // Start conditions
    function trig_ok;
        input [1:0] src;
        input tmr;
        input pin_fall;
        begin
            case (src)
                `ADCMC_TRG_TIMER: trig_ok = tmr;
                `ADCMC_TRG_PIN: trig_ok = pin_fall;
                default: trig_ok = 1'b0;
            endcase
        end
    endfunction

    assign hw_trigger = trig_ok(trigger_source_q, multifunction_timer_trig,
        pin_prev_q && !external_trigger_pin_n);
    assign run_set = (wr_csr && csr_wbyte[`ADCMC_CSR_RUN]) || hw_trigger;

    // ==========================================
    // Channel walk
    assign first_ch = group_mode_select_q ? 3'h0 : channel_code_q;
    assign last_ch = cur_ch_q == channel_code_q;
    assign round_end = conv_done && last_ch;
    assign start_conv = (state_q == ST_IDLE && conversion_run_bit_q) ||
        (state_q == ST_HOLD && !conversion_end_flag_q);
    assign timer_start = start_conv || (conv_done && !round_end) ||
        (round_end && scan_mode_q && !end_interrupt_enable_q);

    // Clear only after the set flag has been read
    assign flag_clear = wr_csr && flag_seen_q && !csr_wbyte[`ADCMC_CSR_FLAG];

    adcmc_conv_timer u_timer
    (
        .clk(clk),
        .rst(rst),
        .clr(standby || !conversion_run_bit_q),
        .start(timer_start),
        .slow(conv_clock_select_q),
        .done_q(conv_done)
    );

    adcmc_result_bank u_bank
    (
        .clk(clk),
        .rst(rst),
        .clr(standby),
        .wr(conv_done && state_q == ST_CONV),
        .ch(cur_ch_q),
        .value(conversion_value_bits),
        .buf_mode(buffer_chain_q),
        .rd_idx(bus_addr[3:1]),
        .rd_value(rd_value)
    );

    // ==========================================
    // Control registers
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            end_interrupt_enable_q <= 1'b0;
            conv_clock_select_q <= 1'b0;
            group_mode_select_q <= 1'b0;
            channel_code_q <= 3'h0;
            start_mode_select_q <= 1'b0;
            trigger_source_q <= `ADCMC_TRG_SW;
            scan_mode_q <= 1'b0;
            dual_sample_enable_q <= 1'b0;
            buffer_chain_q <= `ADCMC_BUF_NONE;
            pin_prev_q <= 1'b1;
        end
        else
        begin
            pin_prev_q <= external_trigger_pin_n;
            if (standby)
            begin
                end_interrupt_enable_q <= 1'b0;
                conv_clock_select_q <= 1'b0;
                group_mode_select_q <= 1'b0;
                channel_code_q <= 3'h0;
                start_mode_select_q <= 1'b0;
                trigger_source_q <= `ADCMC_TRG_SW;
                scan_mode_q <= 1'b0;
                dual_sample_enable_q <= 1'b0;
                buffer_chain_q <= `ADCMC_BUF_NONE;
            end
            else
            begin
                if (wr_csr)
                begin
                    end_interrupt_enable_q <= csr_wbyte[`ADCMC_CSR_IE];
                    conv_clock_select_q <= csr_wbyte[`ADCMC_CSR_CKS];
                    group_mode_select_q <= csr_wbyte[`ADCMC_CSR_GRP];
                    channel_code_q <= csr_wbyte[2:0];
                end
                if (wr_ctrl)
                begin
                    start_mode_select_q <= ctrl_wbyte[`ADCMC_CTRL_PWR];
                    trigger_source_q <= ctrl_wbyte[5:4];
                    scan_mode_q <= ctrl_wbyte[`ADCMC_CTRL_SCAN];
                    dual_sample_enable_q <= ctrl_wbyte[`ADCMC_CTRL_DUAL_SAMPLE_ENABLE];
                    buffer_chain_q <= ctrl_wbyte[1:0];
                end
            end
        end
    end

    // ==========================================
    // Run bit, end flag and sequencer
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            conversion_run_bit_q <= 1'b0;
            conversion_end_flag_q <= 1'b0;
            flag_seen_q <= 1'b0;
            state_q <= ST_IDLE;
            cur_ch_q <= 3'h0;
        end
        else if (standby)
        begin
            conversion_run_bit_q <= 1'b0;
            conversion_end_flag_q <= 1'b0;
            flag_seen_q <= 1'b0;
            state_q <= ST_IDLE;
            cur_ch_q <= 3'h0;
        end
        else
        begin
            // End flag: a completing round wins over a clear
            if (round_end)
                conversion_end_flag_q <= 1'b1;
            else if (flag_clear)
                conversion_end_flag_q <= 1'b0;
            if (bus_req && !bus_we && sel_csr && conversion_end_flag_q)
                flag_seen_q <= 1'b1;
            else if (flag_clear || !conversion_end_flag_q)
                flag_seen_q <= 1'b0;

            // Run bit
            if (run_set)
                conversion_run_bit_q <= 1'b1;
            else if (wr_csr && !csr_wbyte[`ADCMC_CSR_RUN])
                conversion_run_bit_q <= 1'b0;
            else if (round_end && !scan_mode_q)
                conversion_run_bit_q <= 1'b0;

            case (state_q)
                ST_IDLE:
                begin
                    cur_ch_q <= first_ch;
                    if (conversion_run_bit_q)
                        state_q <= ST_CONV;
                end
                ST_CONV:
                begin
                    if (!conversion_run_bit_q)
                        state_q <= ST_IDLE;
                    else if (conv_done)
                    begin
                        cur_ch_q <= last_ch ? first_ch : cur_ch_q + 3'h1;
                        if (last_ch && !scan_mode_q)
                            state_q <= ST_IDLE;
                        else if (last_ch && end_interrupt_enable_q)
                            state_q <= ST_HOLD;
                    end
                end
                ST_HOLD:
                begin
                    if (!conversion_run_bit_q)
                        state_q <= ST_IDLE;
                    else if (!conversion_end_flag_q)
                        state_q <= ST_CONV;
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // ==========================================
    // Analog front end controls and interrupt
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ana_sample_q <= 1'b0;
            ana_dual_q <= 1'b0;
            ana_channel_q <= 3'h0;
            ana_fast_start_q <= 1'b0;
            conversion_end_irq_q <= 1'b0;
        end
        else
        begin
            // Sample strobe at each conversion start
            ana_sample_q <= timer_start && conversion_run_bit_q;
            ana_dual_q <= dual_sample_enable_q;
            ana_channel_q <= cur_ch_q;
            ana_fast_start_q <= start_mode_select_q || conversion_run_bit_q;
            conversion_end_irq_q <= conversion_end_flag_q && end_interrupt_enable_q;
        end
    end

    // ==========================================
    // Read data path
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            bus_rdata_q <= 16'h0000;
            bus_ack_q <= 1'b0;
        end
        else
        begin
            bus_ack_q <= bus_req;
            bus_rdata_q <= 16'h0000;
            if (bus_req && !bus_we)
            begin
                if (sel_res && bus_word)
                    bus_rdata_q <= {6'h00, rd_value};
                else if (sel_res && !bus_addr[0])
                    bus_rdata_q <= {8'h00, rd_value[9:2]};
                else if (sel_res)
                    bus_rdata_q <= {8'h00, rd_value[7:0]};
                else if (sel_csr && bus_word)
                    bus_rdata_q <= {conv_control_status, conv_control};
                else if (sel_csr)
                    bus_rdata_q <= {8'h00, conv_control_status};
                else if (sel_ctrl)
                    bus_rdata_q <= {8'h00, conv_control};
            end
        end
    end

endmodule // adcmc_top

`default_nettype wire

//--- include/adcmc_defines.vh
// Constants for the converter mode control and result readout block
// Contract
// - Run bit is set by software write of one or a selected hardware trigger.
// - Run bit zero keeps conversion halted; it resets to zero.
// - Single mode converts designated channels once, then clears the run bit itself.
// - Scan mode converts repeatedly until software writes the run bit to zero; with interrupt enable one it holds after each round until the end flag clears.
// - Clock select zero gives 40 states at phi/2; one gives 80 states at phi/4.
// - Group select zero is select mode, one is group mode.
// - Channel code n picks channel n, or channels 0 to n in group mode.
// - Top bit of the control register reads zero; software writes zero there.
// - Start-mode bit zero is low power mode, one is high speed start.
// - Trigger source 00 software only, 01 timer, 11 external pin, 10 reserved.
// - Scan bit zero is single mode, one is repeating scan mode.
// - Dual sample bit one samples two channels at the same instant.
// - Buffer code 01 moves each new result into A while A shifts into B.
// - Buffer code 10 chains result 1 into A then C, result 2 into B then D.
// - Buffer code 11 forms a four-deep chain A to B to C to D.
// - Control register clears on power-on reset and standby, not manual reset.
// - Eight 16-bit result registers answer word and byte reads.
// - A word read returns all sixteen bits of a result register.
// - A byte read at the even address returns value bits nine to two.
// - Results hold ten bits, upper six read zero, clear on reset or standby.
// - End flag sets on completion; cleared by reading it as one then writing zero.
// - End flag set with interrupt enable one raises the end interrupt request.
`ifndef ADCMC_DEFINES_VH
`define ADCMC_DEFINES_VH

// ==========================================
// Register offsets, low byte of the address
`define ADCMC_OFS_CSR 8'he0
`define ADCMC_OFS_CTRL 8'he1
`define ADCMC_OFS_RES_BASE 8'hf0
`define ADCMC_RESET_BYTE 8'h00
`define ADCMC_RESET_RES 10'h000

// ==========================================
// Status and control field positions
`define ADCMC_CSR_FLAG 7
`define ADCMC_CSR_IE 6
`define ADCMC_CSR_RUN 5
`define ADCMC_CSR_CKS 4
`define ADCMC_CSR_GRP 3
`define ADCMC_CTRL_TOP 7
`define ADCMC_CTRL_PWR 6
`define ADCMC_CTRL_SCAN 3
`define ADCMC_CTRL_DUAL_SAMPLE_ENABLE 2

// ==========================================
// Trigger source and buffer codes
`define ADCMC_TRG_SW 2'h0
`define ADCMC_TRG_TIMER 2'h1
`define ADCMC_TRG_PIN 2'h3
`define ADCMC_BUF_NONE 2'h0
`define ADCMC_BUF_AB 2'h1
`define ADCMC_BUF_AC_BD 2'h2
`define ADCMC_BUF_ABCD 2'h3

// ==========================================
// Conversion timing
`define ADCMC_TICKS_PER_CONV 5'h14
`define ADCMC_DIV_FAST 2'h1
`define ADCMC_DIV_SLOW 2'h3

`endif

//--- hw/adcmc_conv_timer.v
// Conversion time counter with converter clock divider
`timescale 1ns/1ns
`default_nettype none
`include "adcmc_defines.vh"

module adcmc_conv_timer
(
    // Clock and reset
    input wire clk,
    input wire rst,
    input wire clr,
    // Control
    input wire start,
    input wire slow,
    // Status
    output reg done_q
);

    reg [1:0] div_q;
    reg [4:0] tick_q;
    reg busy_q;
    wire [1:0] div_max;
    wire tick_en;

    assign div_max = slow ? `ADCMC_DIV_SLOW : `ADCMC_DIV_FAST;
    assign tick_en = busy_q && (div_q == div_max);

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            div_q <= 2'h0;
            tick_q <= 5'h00;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            done_q <= 1'b0;
            if (clr)
            begin
                busy_q <= 1'b0;
                div_q <= 2'h0;
                tick_q <= 5'h00;
            end
            else if (start)
            begin
                busy_q <= 1'b1;
                div_q <= 2'h0;
                tick_q <= 5'h00;
            end
            else if (busy_q)
            begin
                div_q <= tick_en ? 2'h0 : div_q + 2'h1;
                if (tick_en)
                begin
                    // 20 converter clocks: 40 or 80 states
                    if (tick_q == `ADCMC_TICKS_PER_CONV - 5'h1)
                    begin
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                    end
                    tick_q <= tick_q + 5'h1;
                end
            end
        end
    end

endmodule // adcmc_conv_timer

`default_nettype wire

//--- hw/adcmc_result_bank.v
// Eight result registers with optional buffer chaining
`timescale 1ns/1ns
`default_nettype none
`include "adcmc_defines.vh"

module adcmc_result_bank
(
    // Clock and reset
    input wire clk,
    input wire rst,
    input wire clr,
    // Store port
    input wire wr,
    input wire [2:0] ch,
    input wire [9:0] value,
    input wire [1:0] buf_mode,
    // Read port
    input wire [2:0] rd_idx,
    output wire [9:0] rd_value
);

    reg [9:0] res_q [0:7];
    integer i;

    assign rd_value = res_q[rd_idx];

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            for (i = 0; i < 8; i = i + 1)
                res_q[i] <= `ADCMC_RESET_RES;
        end
        else if (clr)
        begin
            for (i = 0; i < 8; i = i + 1)
                res_q[i] <= `ADCMC_RESET_RES;
        end
        else if (wr)
        begin
            if (ch == 3'h0 && buf_mode == `ADCMC_BUF_AB)
            begin
                res_q[1] <= res_q[0];
                res_q[0] <= value;
            end
            else if (ch == 3'h0 && buf_mode == `ADCMC_BUF_AC_BD)
            begin
                res_q[2] <= res_q[0];
                res_q[0] <= value;
            end
            else if (ch == 3'h1 && buf_mode == `ADCMC_BUF_AC_BD)
            begin
                res_q[3] <= res_q[1];
                res_q[1] <= value;
            end
            else if (ch == 3'h0 && buf_mode == `ADCMC_BUF_ABCD)
            begin
                res_q[3] <= res_q[2];
                res_q[2] <= res_q[1];
                res_q[1] <= res_q[0];
                res_q[0] <= value;
            end
            else
                res_q[ch] <= value;
        end
    end

endmodule // adcmc_result_bank

`default_nettype wire

//--- tb/adcmc_props.sv
// Port assertions for the converter control and readout block
`timescale 1ns/1ns
`default_nettype none
module adcmc_props
(
    // Clock and resets
    input wire clk,
    input wire rst,
    input wire standby,
    // Register access
    input wire bus_req,
    input wire bus_we,
    input wire bus_word,
    input wire [7:0] bus_addr,
    input wire [15:0] bus_wdata,
    input wire [15:0] bus_rdata_q,
    input wire bus_ack_q,
    // Front end and interrupt
    input wire ana_dual_q,
    input wire conversion_end_irq_q
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    AST_ACK_AFTER_REQ: assert property (bus_req |=> bus_ack_q)
        else $error("request without ack");
    AST_ACK_HAS_CAUSE: assert property (bus_ack_q |-> $past(bus_req))
        else $error("ack without request");
    AST_RDATA_IDLE: assert property (!bus_ack_q |-> bus_rdata_q == 16'h0000)
        else $error("read data outside ack");
    AST_RES_UPPER: assert property ((bus_req && !bus_we && bus_word && bus_addr[7:4] == 4'hf)
        |=> bus_rdata_q[15:10] == 6'h00) else $error("result upper bits set");
    AST_BYTE_UPPER: assert property ((bus_req && !bus_we && !bus_word)
        |=> bus_rdata_q[15:8] == 8'h00) else $error("byte read upper half set");
    AST_CTRL_TOP: assert property ((bus_req && !bus_we && !bus_word && bus_addr == 8'he1)
        |=> !bus_rdata_q[7]) else $error("control top bit reads one");
    AST_STANDBY_IRQ: assert property (standby |-> ##2 !conversion_end_irq_q)
        else $error("irq after standby");
    AST_DUAL_COPY: assert property ((bus_req && bus_we && !bus_word && bus_addr == 8'he1 &&
        !standby) |-> ##2 ana_dual_q == $past(bus_wdata[2], 2)) else $error("dual copy wrong");
    AST_QUIET_RESET: assert property ($fell(rst) |-> !bus_ack_q && !conversion_end_irq_q)
        else $error("activity after reset");

    cover property ($rose(conversion_end_irq_q));
    cover property (bus_ack_q && $past(!bus_word && bus_addr[7:4] == 4'hf));
    cover property (standby);
endmodule // adcmc_props

bind adcmc_top adcmc_props u_adcmc_props (.clk(clk), .rst(rst), .standby(standby),
    .bus_req(bus_req), .bus_we(bus_we), .bus_word(bus_word), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_rdata_q(bus_rdata_q), .bus_ack_q(bus_ack_q),
    .ana_dual_q(ana_dual_q), .conversion_end_irq_q(conversion_end_irq_q));
`default_nettype wire

//--- tb/adcmc_bus_master.sv
// Bus master model issuing register accesses
`timescale 1ns/1ns
`default_nettype none
module adcmc_bus_master
(
    // Clock
    input wire logic clk,
    // Request
    output var logic bus_req,
    output var logic bus_we,
    output var logic bus_word,
    output var logic [7:0] bus_addr,
    output var logic [15:0] bus_wdata,
    // Answer
    input wire logic [15:0] bus_rdata_q,
    input wire logic bus_ack_q
);
    logic timed_out;

    initial
    begin
        bus_req = 1'b0;
        bus_we = 1'b0;
        bus_word = 1'b0;
        bus_addr = 8'h00;
        bus_wdata = 16'h0000;
        timed_out = 1'b0;
    end

    // One-cycle strobe, answer taken at the first edge showing ack
    task automatic acc(input logic we, input logic word, input logic [7:0] addr,
        input logic [15:0] wd, output logic [15:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        bus_req <= 1'b1;
        bus_we <= we;
        bus_word <= word;
        bus_addr <= addr;
        bus_wdata <= wd;
        @(posedge clk);
        bus_req <= 1'b0;
        @(posedge clk);
        while (bus_ack_q !== 1'b1 && n < 4)
        begin
            @(posedge clk);
            n++;
        end
        if (bus_ack_q !== 1'b1)
            timed_out = 1'b1;
        rd = bus_rdata_q;
        // Released data lines do not keep the last value
        bus_wdata <= ~wd;
    endtask

    // Flag clear: status read first, then zero written into the flag
    task automatic clear_flag(input logic [7:0] keep);
        logic [15:0] r;
        acc(1'b0, 1'b0, 8'he0, 16'h0000, r);
        acc(1'b1, 1'b0, 8'he0, {8'h00, 1'b0, keep[6:0]}, r);
    endtask
endmodule // adcmc_bus_master
`default_nettype wire

//--- tb/test_adc_mode_control_and_result_readout.sv
// Self-checking bench for the converter control and readout block
`timescale 1ns/1ns
`default_nettype none
module test_adc_mode_control_and_result_readout;
    logic clk, rst, standby, tmr, pin_n;
    logic [9:0] value, e;
    logic [2:0] tag;
    logic [15:0] r;
    wire [15:0] rdata, wdata;
    wire [7:0] addr;
    wire [2:0] chan;
    wire ack, req, we, word, irq, dual, fast, samp;
    int num_errors, n_tests;
    int n_samp = 0;

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Front end: value encodes the round tag and the channel
    always @(posedge clk)
        value <= {tag, 4'h5, chan};

    // Conversion starts seen at the front end
    always @(posedge clk)
        if (samp === 1'b1)
            n_samp <= n_samp + 1;

    adcmc_top u_adcmc_top (.clk(clk), .rst(rst), .standby(standby), .bus_req(req),
        .bus_we(we), .bus_word(word), .bus_addr(addr), .bus_wdata(wdata),
        .bus_rdata_q(rdata), .bus_ack_q(ack), .multifunction_timer_trig(tmr),
        .external_trigger_pin_n(pin_n), .conversion_value_bits(value),
        .ana_sample_q(samp), .ana_dual_q(dual), .ana_channel_q(chan),
        .ana_fast_start_q(fast), .conversion_end_irq_q(irq));

    adcmc_bus_master u_adcmc_bus_master (.clk(clk), .bus_req(req), .bus_we(we),
        .bus_word(word), .bus_addr(addr), .bus_wdata(wdata), .bus_rdata_q(rdata),
        .bus_ack_q(ack));

    function automatic logic [9:0] v(input logic [2:0] t, input logic [2:0] c);
        return {t, 4'h5, c};
    endfunction

    task automatic stop_test;
        if (u_adcmc_bus_master.timed_out === 1'b1)
            num_errors++;
        if (num_errors == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [15:0] g, input logic [15:0] x);
        n_tests++;
        if (g !== x)
        begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, g, x);
        end
    endtask

    task automatic rd(input logic w, input logic [7:0] a, input logic [15:0] x);
        u_adcmc_bus_master.acc(1'b0, w, a, 16'h0000, r);
        if (u_adcmc_bus_master.timed_out === 1'b1)
            stop_test();
        chk(r, x);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_adcmc_bus_master.acc(1'b1, 1'b0, a, {8'h00, d}, r);
        if (u_adcmc_bus_master.timed_out === 1'b1)
            stop_test();
    endtask

    task automatic res4(input logic [9:0] a, b, c, d);
        rd(1'b1, 8'hf0, {6'h00, a});
        rd(1'b1, 8'hf2, {6'h00, b});
        rd(1'b1, 8'hf4, {6'h00, c});
        rd(1'b1, 8'hf6, {6'h00, d});
    endtask

    // Trigger pulses: bit 0 timer, bit 1 pin falling edge
    task automatic kick(input logic [1:0] how);
        @(posedge clk);
        tmr <= how[0];
        pin_n <= !how[1];
        @(posedge clk);
        tmr <= 1'b0;
        pin_n <= 1'b1;
    endtask

    // One start, bounded wait for the end irq, status check, flag clear
    task automatic conv(input logic [7:0] csr, input int chans, input logic [2:0] t,
        input logic [1:0] how, input logic [7:0] st);
        int n, lo, ns;
        n = 0;
        ns = n_samp;
        tag = t;
        lo = chans * (csr[4] ? 80 : 40);
        if (how == 2'b00)
            wr(8'he0, csr);
        else
        begin
            wr(8'he0, csr & 8'hdf);
            kick(how);
        end
        while (irq !== 1'b1 && n < 2000)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 2000)
        begin
            num_errors++;
            stop_test();
        end
        chk({15'h0000, n >= lo && n <= lo + 4 * chans + 6}, 16'h0001);
        chk(16'(n_samp - ns), 16'(chans));
        rd(1'b0, 8'he0, {8'h00, st});
        u_adcmc_bus_master.clear_flag(8'h40);
        if (u_adcmc_bus_master.timed_out === 1'b1)
            stop_test();
    endtask

    initial
    begin
        rst = 1'b1;
        standby = 1'b0;
        tmr = 1'b0;
        pin_n = 1'b1;
        tag = 3'h0;
        num_errors = 0;
        n_tests = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(1'b0, 8'he0, 16'h0000);
        rd(1'b0, 8'he1, 16'h0000);
        for (int i = 0; i < 8; i++)
            rd(1'b1, 8'hf0 + 8'(2 * i), 16'h0000);
        rd(1'b0, 8'h10, 16'h0000);
        wr(8'he1, 8'hff);
        rd(1'b0, 8'he1, 16'h007f);
        rd(1'b1, 8'he0, 16'h007f);
        chk({15'h0000, dual}, 16'h0001);
        chk({15'h0000, fast}, 16'h0001);
        wr(8'he1, 8'h00);
        conv(8'h63, 1, 3'h1, 2'b00, 8'hc3);
        e = v(3'h1, 3'h3);
        rd(1'b1, 8'hf6, {6'h00, e});
        rd(1'b0, 8'hf6, {8'h00, e[9:2]});
        rd(1'b0, 8'hf7, {8'h00, e[7:0]});
        rd(1'b1, 8'hf0, 16'h0000);
        conv(8'h7a, 3, 3'h2, 2'b00, 8'hda);
        res4(v(3'h2, 3'h0), v(3'h2, 3'h1), v(3'h2, 3'h2), e);
        wr(8'he1, 8'h03);
        for (int t = 3; t < 7; t++)
            conv(8'h60, 1, 3'(t), 2'b00, 8'hc0);
        res4(v(3'h6, 3'h0), v(3'h5, 3'h0), v(3'h4, 3'h0), v(3'h3, 3'h0));
        wr(8'he1, 8'h01);
        conv(8'h60, 1, 3'h7, 2'b00, 8'hc0);
        conv(8'h60, 1, 3'h0, 2'b00, 8'hc0);
        res4(v(3'h0, 3'h0), v(3'h7, 3'h0), v(3'h4, 3'h0), v(3'h3, 3'h0));
        wr(8'he1, 8'h02);
        conv(8'h69, 2, 3'h2, 2'b00, 8'hc9);
        res4(v(3'h2, 3'h0), v(3'h2, 3'h1), v(3'h0, 3'h0), v(3'h7, 3'h0));
        wr(8'he1, 8'h08);
        conv(8'h60, 1, 3'h1, 2'b00, 8'he0);
        repeat (100) @(posedge clk);
        rd(1'b0, 8'he0, 16'h0040);
        rd(1'b1, 8'hf0, {6'h00, v(3'h1, 3'h0)});
        wr(8'he1, 8'h10);
        conv(8'h60, 1, 3'h2, 2'b01, 8'hc0);
        wr(8'he1, 8'h30);
        conv(8'h60, 1, 3'h3, 2'b10, 8'hc0);
        rd(1'b1, 8'hf0, {6'h00, v(3'h3, 3'h0)});
        for (int k = 0; k < 2; k++)
        begin
            wr(8'he1, k == 0 ? 8'h20 : 8'h00);
            kick(2'b11);
            repeat (200) @(posedge clk);
            rd(1'b0, 8'he0, 16'h0040);
        end
        wr(8'he1, 8'h20);
        conv(8'h60, 1, 3'h4, 2'b00, 8'hc0);
        wr(8'he0, 8'hc0);
        rd(1'b0, 8'he0, 16'h0040);
        wr(8'he1, 8'h05);
        @(posedge clk);
        standby <= 1'b1;
        @(posedge clk);
        standby <= 1'b0;
        rd(1'b0, 8'he1, 16'h0000);
        rd(1'b0, 8'he0, 16'h0000);
        rd(1'b1, 8'hf0, 16'h0000);
        stop_test();
    end
endmodule // test_adc_mode_control_and_result_readout
`default_nettype wire
